/* File: udtc_pkg.sv */
package udtc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTL = 8'h00;
	localparam logic [7:0] REG_SHARED = 8'h04;
	localparam logic [7:0] REG_PER = 8'h08;
	localparam logic [7:0] REG_CMP = 8'h0c;
	localparam logic [7:0] REG_CNT = 8'h10;
	localparam logic [7:0] REG_FLAGS = 8'h14;

	// ----------------------------------------------------------------
	// timer control fields
	// ----------------------------------------------------------------
	localparam int CTL_CMP_EN = 1;
	localparam int CTL_CLK_LO = 4;
	localparam int CTL_RUN = 6;
	localparam int CTL_PSC_LO = 8;
	localparam int CTL_MODE_LO = 11;

	localparam logic [1:0] CLK_EXT = 2'h1;

	localparam logic [2:0] MODE_HOLD = 3'h0;
	localparam logic [2:0] MODE_SINGLE_UP = 3'h1;
	localparam logic [2:0] MODE_CONT_UP = 3'h2;
	localparam logic [2:0] MODE_DIR_UD = 3'h3;
	localparam logic [2:0] MODE_SINGLE_UD = 3'h4;
	localparam logic [2:0] MODE_CONT_UD = 3'h5;

	// ----------------------------------------------------------------
	// shared output control fields
	// ----------------------------------------------------------------
	localparam int SH_OUT_LO = 0;
	localparam int SH_OUT_EN = 6;
	localparam int SH_ADC_LO = 7;
	localparam int SH_DIR = 13;
	localparam logic [15:0] SH_WMASK = 16'h1fff;

	localparam logic [1:0] OUT_FORCE_LO = 2'h0;
	localparam logic [1:0] OUT_ACT_LO = 2'h1;
	localparam logic [1:0] OUT_ACT_HI = 2'h2;
	localparam logic [1:0] OUT_FORCE_HI = 2'h3;
	localparam logic [1:0] ADC_ON_CMP = 2'h2;

	// ----------------------------------------------------------------
	// event flags
	// ----------------------------------------------------------------
	localparam int FLG_PER = 0;
	localparam int FLG_UND = 1;
	localparam int FLG_OVF = 2;
	localparam int FLG_CMP = 3;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] SH_RST = 16'h0000;
	localparam logic [15:0] PER_RST = 16'h0000;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [6:0] PSC_RST = 7'h00;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} udtc_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} udtc_wb_rsp_t;

endpackage

/* File: udtc_timer.sv */
`timescale 1ns/1ps

// Contract
// - single up/down: up, down, stop at zero
// - single run from zero lasts twice period
// - single: start above period wraps through max
// - single: start at period counts down, ends
// - start below period climbs, then finishes normally
// - period/underflow/overflow flags as single up
// - direction status reads one up, zero down
// - either clock source; direction pin ignored
// - continuous mode repeats without intervention
// - continuous period lasts twice period value
// - continuous: start at period, down, cycle
// - continuous: start above period wraps to zero
// - counter compared to compare register on the cycle after each update
// - compare flag set two cycles after match
// - output changes one cycle after match
// - adc start pulses with compare flag set
// - compare disabled: output tristate, no compare events
// - output depends on config, mode, direction
// - directional mode: no compare output transitions
module udtc_timer
	import udtc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire udtc_wb_req_t wb_req,
	output udtc_wb_rsp_t wb_rsp,
	input wire logic ext_clk_pin,
	output logic compare_pwm_pin_o,
	output logic compare_pwm_pin_oe,
	output logic adc_start
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] shared;
		logic [15:0] per;
		logic [15:0] cmp;
		logic [15:0] cnt;
		logic [3:0] flags;
		logic dir;
		logic [6:0] psc;
		logic [2:0] ext_sync;
		logic upd;
		logic match_q;
		logic wave;
		logic pin;
		logic pin_oe;
		logic adc;
		logic ack;
		logic [31:0] rdat;
	} udtc_state_t;

	udtc_state_t s;
	udtc_state_t next_s;

	function automatic logic [15:0] udtc_bw(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		udtc_bw = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic udtc_updown(input logic [2:0] m);
		udtc_updown = (m == MODE_SINGLE_UD) || (m == MODE_CONT_UD);
	endfunction

	function automatic logic udtc_level(input logic [1:0] cfg, input logic w);
		case (cfg)
			OUT_FORCE_LO: udtc_level = 1'b0;
			OUT_ACT_LO: udtc_level = ~w;
			OUT_ACT_HI: udtc_level = w;
			default: udtc_level = 1'b1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [2:0] mode;
	logic updown;
	logic single;
	logic dirmode;
	logic run;
	logic cmp_en;
	logic src;
	logic [6:0] psc_max;
	logic tick;
	logic cmp_match;
	logic acc;
	logic wr;
	logic rd;
	logic cnt_wr;
	logic [3:0] fset;
	logic [3:0] fclr;
	logic [15:0] sh_rd;

	assign mode = s.ctl[CTL_MODE_LO +: 3];
	assign updown = udtc_updown(mode);
	assign single = (mode == MODE_SINGLE_UD);
	assign dirmode = (mode == MODE_DIR_UD);
	assign run = s.ctl[CTL_RUN];
	assign cmp_en = s.ctl[CTL_CMP_EN];
	// external clock counts rising edges seen after the synchroniser
	assign src = (s.ctl[CTL_CLK_LO +: 2] == CLK_EXT) ? (s.ext_sync[1] & ~s.ext_sync[2]) : 1'b1;
	assign psc_max = 7'((8'h01 << s.ctl[CTL_PSC_LO +: 3]) - 8'h01);
	assign tick = run & updown & src & (s.psc == psc_max);
	// compared only on the cycle right after an update
	assign cmp_match = s.upd & cmp_en & (s.cnt == s.cmp);
	assign acc = wb_req.cyc & wb_req.stb & ~s.ack;
	assign wr = acc & wb_req.we;
	assign rd = acc & ~wb_req.we;
	assign cnt_wr = wr & (wb_req.adr == REG_CNT);

	always_comb begin
		sh_rd = s.shared;
		sh_rd[SH_DIR] = s.dir;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ext_sync = {s.ext_sync[1:0], ext_clk_pin};
		next_s.upd = 1'b0;
		next_s.ack = acc;
		next_s.adc = 1'b0;
		fset = 4'h0;
		fclr = 4'h0;

		if (run & updown & src) begin
			next_s.psc = tick ? PSC_RST : 7'(s.psc + 7'h01);
		end

		if (tick) begin
			next_s.upd = 1'b1;
			if (s.dir) begin
				if (s.cnt == s.per && s.per != CNT_RST) begin
					// turn round at the top; takes effect on this tick
					next_s.dir = 1'b0;
					next_s.cnt = s.cnt - 16'h0001;
				end else if (s.cnt != s.per) begin
					// above period the count runs on and wraps through zero
					next_s.cnt = s.cnt + 16'h0001;
				end else if (single) begin
					next_s.ctl[CTL_RUN] = 1'b0;
					next_s.psc = PSC_RST;
				end
			end else if (s.cnt == CNT_RST) begin
				// bottom of a continuous cycle: start the next period
				next_s.dir = 1'b1;
				next_s.cnt = 16'h0001;
			end else begin
				next_s.cnt = s.cnt - 16'h0001;
				if (single && s.cnt == 16'h0001) begin
					// stop and hold; only software starts it again
					next_s.ctl[CTL_RUN] = 1'b0;
					next_s.psc = PSC_RST;
					next_s.dir = 1'b1;
				end
			end
		end

		if (s.upd) begin
			fset[FLG_PER] = (s.cnt == s.per);
			fset[FLG_UND] = (s.cnt == CNT_RST);
			fset[FLG_OVF] = (s.cnt == CNT_MAX);
		end

		next_s.match_q = cmp_match;
		if (s.match_q) begin
			fset[FLG_CMP] = 1'b1;
			next_s.adc = (s.shared[SH_ADC_LO +: 2] == ADC_ON_CMP);
		end

		// directional mode freezes the waveform completely
		if (!dirmode) begin
			if (!cmp_en) begin
				next_s.wave = 1'b0;
			end else if (cmp_match) begin
				next_s.wave = ~s.wave;
			end else if (s.upd && s.cnt == CNT_RST && s.cmp != CMP_RST) begin
				// end of period; a zero compare keeps a 100% pulse glitch free
				next_s.wave = 1'b0;
			end
		end

		if (wr) begin
			case (wb_req.adr)
				REG_CTL: begin
					next_s.ctl = udtc_bw(s.ctl, wb_req.dat, wb_req.sel);
					if (!run && next_s.ctl[CTL_RUN]) begin
						next_s.dir = 1'b1;
						next_s.psc = PSC_RST;
					end
				end
				REG_SHARED: begin
					next_s.shared = udtc_bw(s.shared, wb_req.dat, wb_req.sel) & SH_WMASK;
				end
				REG_PER: begin
					next_s.per = udtc_bw(s.per, wb_req.dat, wb_req.sel);
				end
				REG_CMP: begin
					next_s.cmp = udtc_bw(s.cmp, wb_req.dat, wb_req.sel);
				end
				REG_CNT: begin
					next_s.cnt = udtc_bw(s.cnt, wb_req.dat, wb_req.sel);
				end
				REG_FLAGS: begin
					fclr = wb_req.sel[0] ? wb_req.dat[3:0] : 4'h0;
				end
				default: begin
				end
			endcase
		end
		// a hardware set beats a same-cycle clear
		next_s.flags = (s.flags & ~fclr) | fset;

		// output stage: tristate whenever compare or outputs are off
		next_s.pin_oe = cmp_en & s.shared[SH_OUT_EN];
		next_s.pin = udtc_level(s.shared[SH_OUT_LO +: 2], next_s.wave);

		if (rd) begin
			case (wb_req.adr)
				REG_CTL: next_s.rdat = {16'h0000, s.ctl};
				REG_SHARED: next_s.rdat = {16'h0000, sh_rd};
				REG_PER: next_s.rdat = {16'h0000, s.per};
				REG_CMP: next_s.rdat = {16'h0000, s.cmp};
				REG_CNT: next_s.rdat = {16'h0000, s.cnt};
				REG_FLAGS: next_s.rdat = {28'h0000000, s.flags};
				default: next_s.rdat = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.ctl <= CTL_RST;
			s.shared <= SH_RST;
			s.per <= PER_RST;
			s.cmp <= CMP_RST;
			s.cnt <= CNT_RST;
			s.dir <= 1'b1;
			s.psc <= PSC_RST;
		end else begin
			s <= next_s;
		end
	end

	assign wb_rsp.ack = s.ack;
	assign wb_rsp.dat = s.rdat;
	assign compare_pwm_pin_o = s.pin;
	assign compare_pwm_pin_oe = s.pin_oe;
	assign adc_start = s.adc;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking udtc_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	chk_single_stop_zero: assert property (
		(tick && single && !s.dir && s.cnt == 16'h0001 && !wr) |=> (!run && s.cnt == CNT_RST && s.psc == PSC_RST))
		else $error("single up/down run did not stop at zero");

	chk_cmp_flag_delay: assert property (
		cmp_match |-> ##2 s.flags[FLG_CMP])
		else $error("compare flag not set two cycles after match");

	chk_wave_toggle: assert property (
		(cmp_match && !dirmode) |=> (s.wave != $past(s.wave)))
		else $error("compare output did not change one cycle after match");

	chk_adc_with_flag: assert property (
		adc_start |-> (s.flags[FLG_CMP] && $past(cmp_match, 2)))
		else $error("adc start without compare flag set");

	chk_disabled_quiet: assert property (
		(!$past(cmp_en, 2) && !$past(cmp_en)) |-> (!compare_pwm_pin_oe && !adc_start && !s.match_q))
		else $error("compare disabled but output or events active");

	chk_dir_turn: assert property (
		(tick && s.dir && s.cnt == s.per && s.per != CNT_RST && !wr) |=> (!s.dir && sh_rd[SH_DIR] == 1'b0))
		else $error("direction did not turn at period");

	chk_wrap_max: assert property (
		(tick && s.dir && s.cnt == CNT_MAX && s.per != CNT_MAX && !cnt_wr) |=> (s.cnt == CNT_RST && s.dir))
		else $error("count above period did not wrap to zero");

	chk_dir_frozen: assert property (
		dirmode |=> $stable(s.wave))
		else $error("compare output moved in directional mode");

	chk_tick_only: assert property (
		(!tick && !cnt_wr) |=> $stable(s.cnt))
		else $error("counter moved without a tick");

	chk_cont_restart: assert property (
		(tick && mode == MODE_CONT_UD && !s.dir && s.cnt == CNT_RST && !wr) |=> (s.dir && s.cnt == 16'h0001 && run))
		else $error("continuous mode did not start the next period");

	chk_one_match: assert property (
		cmp_match |-> $past(tick))
		else $error("compare match without a counter update");

	chk_cmp_adc_pulse: assert property (
		(cmp_match && s.shared[SH_ADC_LO +: 2] == ADC_ON_CMP && !wr) |-> ##2 adc_start)
		else $error("adc start missing after compare match");

	chk_oe_off: assert property (
		!cmp_en |=> !compare_pwm_pin_oe)
		else $error("output driven with compare disabled");

	chk_oe_on: assert property (
		(cmp_en && s.shared[SH_OUT_EN]) |=> compare_pwm_pin_oe)
		else $error("output not driven with compare enabled");

	chk_stop_dir_up: assert property (
		(tick && single && !s.dir && s.cnt == 16'h0001 && !wr) |=> s.dir)
		else $error("direction status not up after a finished run");

	chk_up_step: assert property (
		(tick && s.dir && s.cnt != s.per && !cnt_wr) |=> (s.cnt == 16'($past(s.cnt) + 16'h0001)))
		else $error("counter did not step up on a tick");

	chk_down_step: assert property (
		(tick && !s.dir && s.cnt != CNT_RST && !cnt_wr) |=> (s.cnt == 16'($past(s.cnt) - 16'h0001)))
		else $error("counter did not step down on a tick");

	chk_cont_top_turn: assert property (
		(tick && mode == MODE_CONT_UD && s.dir && s.cnt == s.per && s.per != CNT_RST && !wr) |=> (!s.dir && run))
		else $error("continuous mode did not turn down at period");

	chk_per_flag: assert property (
		(s.upd && s.cnt == s.per) |=> s.flags[FLG_PER])
		else $error("period flag not set on period match");

	chk_und_flag: assert property (
		(s.upd && s.cnt == CNT_RST) |=> s.flags[FLG_UND])
		else $error("underflow flag not set at zero");

	chk_ovf_flag: assert property (
		(s.upd && s.cnt == CNT_MAX) |=> s.flags[FLG_OVF])
		else $error("overflow flag not set at maximum");

	chk_no_restart: assert property (
		(!run && !wr) |=> !run)
		else $error("timer started without a software write");

	chk_ext_edge: assert property (
		(s.ctl[CTL_CLK_LO +: 2] == CLK_EXT && !(s.ext_sync[1] && !s.ext_sync[2])) |-> !tick)
		else $error("tick without an external clock edge");

	chk_cmp_flag_hold: assert property (
		(s.flags[FLG_CMP] && !wr) |=> s.flags[FLG_CMP])
		else $error("compare flag lost without a clear");

	chk_pin_act_hi: assert property (
		(s.shared[SH_OUT_LO +: 2] == OUT_ACT_HI) |=> (compare_pwm_pin_o == s.wave))
		else $error("active high output does not follow waveform");

	chk_pin_act_lo: assert property (
		(s.shared[SH_OUT_LO +: 2] == OUT_ACT_LO) |=> (compare_pwm_pin_o != s.wave))
		else $error("active low output does not invert waveform");

	chk_pin_force_hi: assert property (
		(s.shared[SH_OUT_LO +: 2] == OUT_FORCE_HI) |=> compare_pwm_pin_o)
		else $error("forced high output not high");

	chk_pin_force_lo: assert property (
		(s.shared[SH_OUT_LO +: 2] == OUT_FORCE_LO) |=> !compare_pwm_pin_o)
		else $error("forced low output not low");

endmodule

/* File: udtc_timer_tb.sv */
`timescale 1ns/1ps
module udtc_timer_tb
	import udtc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ext_clk_pin = 1'b0;
	logic [1:0] ext_div = 2'h0;
	udtc_wb_req_t wb_req = '0;
	udtc_wb_rsp_t wb_rsp;
	logic pin_o, pin_oe, adc_start;
	logic [15:0] got, k;
	logic [1:0] lane = 2'h3;
	logic [32:0] e_rd;
	logic [32:0] rdq[$];
	logic pinq[$];
	int gapq[$];
	int miscompares = 0, checked = 0, cyc = 0, n_adc = 0, last_adc = -1, tn = 0, p, c;

	always #2 core_clk = ~core_clk;

	udtc_timer i_dut(.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.ext_clk_pin(ext_clk_pin), .compare_pwm_pin_o(pin_o), .compare_pwm_pin_oe(pin_oe),
		.adc_start(adc_start));

	// ------------------------------------------------
	// compare and bus helpers
	// ------------------------------------------------
	task automatic note(input logic ok, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (!ok) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_dat(input logic [31:0] g, input logic [31:0] e);
		note(g === e, g, e);
	endtask
	task automatic chk_pin(input logic g, input logic e);
		note(g === e, {31'h0, g}, {31'h0, e});
	endtask
	task automatic chk_num(input int g, input int e);
		note(g == e, 32'(g), 32'(e));
	endtask
	task automatic give_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read expectations go to the queue; the watcher compares them at ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic m, input logic [15:0] e);
		if (!w) rdq.push_back({m, 16'h0, e});
		@(posedge core_clk);
		// unused lanes and upper data carry noise the block must ignore
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: {2'($urandom), lane}, dat: {16'($urandom), d}};
		do @(posedge core_clk); while (wb_rsp.ack !== 1'b1);
		got = wb_rsp.dat[15:0];
		wb_req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 1'b0, 16'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0, 1'b1, e);
	endtask
	function automatic logic [15:0] ctl(input logic [2:0] m, input logic [2:0] q, input logic e, input logic [1:0] s);
		return (16'(m) << CTL_MODE_LO) | (16'(q) << CTL_PSC_LO) | (16'(s) << CTL_CLK_LO)
			| (16'(e) << CTL_CMP_EN) | (16'h1 << CTL_RUN);
	endfunction
	function automatic logic [15:0] sh(input logic [1:0] o);
		return 16'(o) | (16'h1 << SH_OUT_EN) | (16'(ADC_ON_CMP) << SH_ADC_LO);
	endfunction
	task automatic go(input logic [15:0] v, input logic [15:0] per, input logic [15:0] cm, input logic [15:0] cn,
		input logic [1:0] o);
		wr(REG_CTL, 16'h0);
		wr(REG_PER, per);
		wr(REG_CMP, cm);
		wr(REG_CNT, cn);
		wr(REG_SHARED, sh(o));
		wr(REG_FLAGS, 16'h000f);
		n_adc = 0;
		last_adc = -1;
		wr(REG_CTL, v);
	endtask
	task automatic fin(input logic [15:0] v, input logic [15:0] fl, input int np);
		for (int i = 0; i < 400; i++) begin
			bus(1'b0, REG_CTL, 16'h0, 1'b0, 16'h0);
			if (got[CTL_RUN] === 1'b0) break;
		end
		rd(REG_CTL, v & ~(16'h1 << CTL_RUN));
		rd(REG_CNT, 16'h0);
		rd(REG_FLAGS, fl);
		chk_num(n_adc, np);
	endtask
	task automatic endt();
		$display("test %0d done", tn);
		tn++;
	endtask

	// ------------------------------------------------
	// watcher, external clock and timeout
	// ------------------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && rdq.size() > 0) begin
			e_rd = rdq.pop_front();
			if (e_rd[32]) chk_dat(wb_rsp.dat, e_rd[31:0]);
		end
		if (adc_start === 1'b1) begin
			n_adc++;
			if (pinq.size() > 0) chk_pin(pin_o, pinq.pop_front());
			if (last_adc >= 0 && gapq.size() > 0) chk_num(cyc - last_adc, gapq.pop_front());
			last_adc = cyc;
		end
	end
	always @(posedge core_clk) begin
		ext_div <= ext_div + 2'h1;
		if (ext_div == 2'h3) ext_clk_pin <= ~ext_clk_pin;
	end
	// whole run needs under a thousand cycles
	always @(posedge core_clk) if (cyc > 20000) begin
		miscompares++;
		give_verdict();
	end

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		p = $urandom(15044);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(REG_CTL, CTL_RST);
		rd(REG_SHARED, 16'h2000);
		rd(REG_PER, PER_RST);
		rd(REG_CMP, CMP_RST);
		rd(REG_CNT, CNT_RST);
		wr(8'h18, 16'hffff);
		rd(8'h18, 16'h0);
		chk_pin(pin_oe, 1'b0);
		// single byte lanes merge into the old value
		lane = 2'h1;
		wr(REG_PER, 16'habcd);
		lane = 2'h2;
		wr(REG_PER, 16'h1234);
		lane = 2'h3;
		rd(REG_PER, 16'h12cd);
		endt();
		p = 2 + $urandom % 8;
		c = 1 + $urandom % (p - 1);
		gapq.push_back((2 * p - 2 * c) * 2);
		pinq.push_back(1'b1);
		pinq.push_back(1'b0);
		k = ctl(MODE_SINGLE_UD, 3'h1, 1'b1, 2'h0);
		go(k, 16'(p), 16'(c), 16'h0, OUT_ACT_HI);
		fin(k, 16'h000b, 2);
		rd(REG_SHARED, sh(OUT_ACT_HI) | 16'h2000);
		chk_pin(pin_o, 1'b0);
		repeat (50) @(posedge core_clk);
		rd(REG_CNT, 16'h0);
		chk_num(n_adc, 2);
		endt();
		// slow prescale leaves time to read the falling direction
		pinq.push_back(1'b0);
		k = ctl(MODE_SINGLE_UD, 3'h7, 1'b1, 2'h0);
		go(k, 16'h2, 16'h1, 16'h2, OUT_ACT_LO);
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, REG_CNT, 16'h0, 1'b0, 16'h0);
			if (got === 16'h1) break;
		end
		rd(REG_SHARED, sh(OUT_ACT_LO));
		fin(k, 16'h000a, 1);
		chk_pin(pin_o, 1'b1);
		endt();
		gapq.push_back(4);
		pinq.push_back(1'b1);
		pinq.push_back(1'b0);
		k = ctl(MODE_SINGLE_UD, 3'h0, 1'b1, 2'h0);
		go(k, 16'h3, 16'h1, 16'hfffd, OUT_ACT_HI);
		fin(k, 16'h000f, 2);
		endt();
		gapq = '{6, 2, 6};
		pinq = '{1'b1, 1'b0, 1'b1, 1'b0};
		go(ctl(MODE_CONT_UD, 3'h0, 1'b1, 2'h0), 16'h4, 16'h1, 16'h0, OUT_ACT_HI);
		for (int i = 0; i < 200 && n_adc < 4; i++) @(posedge core_clk);
		chk_num(n_adc, 4);
		endt();
		k = ctl(MODE_SINGLE_UD, 3'h0, 1'b0, 2'h0);
		go(k, 16'h2, 16'h1, 16'h0, OUT_ACT_HI);
		fin(k, 16'h0003, 0);
		chk_pin(pin_oe, 1'b0);
		endt();
		gapq.push_back(16);
		pinq = '{1'b1, 1'b0};
		k = ctl(MODE_SINGLE_UD, 3'h0, 1'b1, CLK_EXT);
		go(k, 16'h2, 16'h1, 16'h0, OUT_ACT_HI);
		fin(k, 16'h000b, 2);
		endt();
		go(ctl(MODE_DIR_UD, 3'h0, 1'b1, 2'h0), 16'h3, 16'h5, 16'h5, OUT_ACT_HI);
		repeat (40) @(posedge core_clk);
		rd(REG_CNT, 16'h5);
		chk_num(n_adc, 0);
		wr(REG_CTL, 16'h1 << CTL_CMP_EN);
		wr(REG_SHARED, sh(OUT_FORCE_HI));
		repeat (2) @(posedge core_clk);
		chk_pin(pin_o, 1'b1);
		chk_pin(pin_oe, 1'b1);
		wr(REG_SHARED, sh(OUT_FORCE_LO));
		repeat (2) @(posedge core_clk);
		chk_pin(pin_o, 1'b0);
		endt();
		give_verdict();
	end
endmodule
